// ---- src/cic_pkg.sv ----
// Purpose: Constants and types shared by the core interrupt controller.
// Assumes: APB with 32-bit data; every register takes one aligned word.
// Notes:   Contract
// Contract
// - Sixteen priority levels and up to 44 maskable external sources.
// - Four local lines go straight to the core, bypassing arbitration.
// - External sources are arbitrated by programmable priority against a threshold.
// - Each source has a fixed identifier 1 to 44; DMA uses 32, 33, 34.
// - Priority: local 3, 2, 1, 0, external, software, timer.
// - Each interrupt type also needs its own enable bit in the core.
// - Bit 0 of the software register: write 1 pends, write 0 clears.
// - Timer compare is readable and writable as low and high words.
// - Timer count is readable and writable as low and high words.
// - Per-source priority 0 to 15 at base plus four times identifier; 0 disables.
// - Hardware sets pending bit at the source identifier; software cannot.
// - Per-source enable bit, freely set or cleared by software.
// - Only enabled pending sources above the 4-bit threshold request the core.
// - Claim read returns best eligible identifier and clears its pending bit; the code keeps it set while the synchronised source is still high.
// - Claim read returns zero when nothing is eligible.
// - Writing the identifier back completes it and rearms the source.
package cic_pkg;
    localparam int          CIC_NSRC       = 44;
    localparam int          CIC_PRIO_W     = 4;
    localparam int          CIC_ID_W       = 6;
    localparam int          CIC_NLOCAL     = 4;
    localparam logic [31:0] CIC_SWI_ADDR   = 32'h0200_0000;
    localparam logic [31:0] CIC_CMPLO_ADDR = 32'h0200_4000;
    localparam logic [31:0] CIC_CMPHI_ADDR = 32'h0200_4004;
    localparam logic [31:0] CIC_CNTLO_ADDR = 32'h0200_bff8;
    localparam logic [31:0] CIC_CNTHI_ADDR = 32'h0200_bffc;
    localparam logic [31:0] CIC_PRIO_BASE  = 32'h0c00_0000;
    localparam logic [31:0] CIC_PEND_ADDR  = 32'h0c00_1000;
    localparam logic [31:0] CIC_PEND1_ADDR = 32'h0c00_1004;
    localparam logic [31:0] CIC_EN_ADDR    = 32'h0c00_2000;
    localparam logic [31:0] CIC_EN1_ADDR   = 32'h0c00_2004;
    localparam logic [31:0] CIC_THR_ADDR   = 32'h0c20_0000;
    localparam logic [31:0] CIC_CLAIM_ADDR = 32'h0c20_0004;
    localparam logic [31:0] CIC_CMP_RST_LO = 32'hffff_ffff;
    localparam logic [31:0] CIC_CMP_RST_HI = 32'hffff_ffff;
    localparam logic [3:0]  CIC_THR_RST    = 4'h0;

    // Decoded request from the APB side.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cic_req_s;

    // Core interrupt request lines in priority order.
    typedef struct packed {
        logic [3:0] local_irq;
        logic       ext_irq;
        logic       sw_irq;
        logic       tmr_irq;
    } cic_irq_s;
endpackage : cic_pkg

// ---- src/cic_top.sv ----
// Purpose: Core interrupt controller: external arbiter, software and timer unit, local lines.
// Assumes: One clock; APB slave with zero wait states; sources are level or pulse inputs.
// Notes:   Interrupt ids run 1..44; id 0 means no source.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cic_top
    import cic_pkg::*;
(
    input  wire logic                  I_CLK,
    input  wire logic                  I_RST_B,
    input  wire logic                  I_PSEL,
    input  wire logic                  I_PENABLE,
    input  wire logic                  I_PWRITE,
    input  wire logic [31:0]           I_PADDR,
    input  wire logic [31:0]           I_PWDATA,
    input  wire logic [3:0]            I_PSTRB,
    output logic      [31:0]           O_PRDATA,
    output logic                       O_PREADY,
    output logic                       O_PSLVERR,
    input  wire logic [CIC_NSRC:1]     I_SRC_IRQ,
    input  wire logic [CIC_NLOCAL-1:0] I_LOCAL_IRQ,
    input  wire logic                  I_TIMER_TICK,
    output logic                       O_EXT_IRQ,
    output logic                       O_SW_IRQ,
    output logic                       O_TMR_IRQ,
    output logic      [CIC_NLOCAL-1:0] O_LOCAL_IRQ,
    output logic      [6:0]            O_IRQ_VEC
);
    // Source inputs are from other domains or pins: two-stage synchronisers.
    logic [CIC_NSRC:1]     src_s1_r, src_s2_r;
    logic [CIC_NLOCAL-1:0] loc_s1_r, loc_s2_r;
    logic                  tick_s1_r, tick_s2_r;
    logic [CIC_PRIO_W-1:0] prio_r [1:CIC_NSRC];
    logic [CIC_NSRC:1]     pend_r, en_r, busy_r;
    logic [CIC_PRIO_W-1:0] thr_r;
    logic                  swi_r;
    logic [63:0]           cmp_r, cnt_r;
    cic_req_s              req;
    logic                  claim_rd;
    logic [CIC_ID_W-1:0]   best_id;
    logic [CIC_PRIO_W-1:0] best_prio;
    logic [CIC_ID_W-1:0]   done_id;
    logic                  done_wr;
    logic [31:0]           rdata_nxt;
    logic                  hit;
    logic [CIC_ID_W-1:0]   claim_id_r;
    logic [31:0]           en_lo_wr;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            src_s1_r  <= '0;
            src_s2_r  <= '0;
            loc_s1_r  <= '0;
            loc_s2_r  <= '0;
            tick_s1_r <= 1'b0;
            tick_s2_r <= 1'b0;
        end else begin
            src_s1_r  <= I_SRC_IRQ;
            src_s2_r  <= src_s1_r;
            loc_s1_r  <= I_LOCAL_IRQ;
            loc_s2_r  <= loc_s1_r;
            tick_s1_r <= I_TIMER_TICK;
            tick_s2_r <= tick_s1_r;
        end
    end

    // Access phase is taken in one cycle, so PREADY is high on every access edge.
    always_comb begin
        req.wr    = I_PSEL & I_PENABLE & I_PWRITE;
        req.rd    = I_PSEL & I_PENABLE & ~I_PWRITE;
        req.addr  = I_PADDR;
        req.wdata = I_PWDATA;
    end

    // Byte lanes merge a write into an old word; a write with no strobe bits set leaves the word unchanged.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction

    // A source at an id is addressed by base plus four times the id.
    function automatic logic prio_hit(input logic [31:0] a, input int id);
        return a == (CIC_PRIO_BASE + 32'(id * 4));
    endfunction

    // Arbiter: strictly above threshold, enabled, pending; lowest id wins a tie.
    always_comb begin
        best_id   = '0;
        best_prio = thr_r;
        for (int i = 1; i <= CIC_NSRC; i++) begin
            if (pend_r[i] && en_r[i] && !busy_r[i] && prio_r[i] > best_prio) begin
                best_prio = prio_r[i];
                best_id   = CIC_ID_W'(i);
            end
        end
    end

    assign claim_rd = req.rd && (req.addr == CIC_CLAIM_ADDR);
    assign done_wr  = req.wr && (req.addr == CIC_CLAIM_ADDR);
    assign done_id  = req.wdata[CIC_ID_W-1:0];
    assign en_lo_wr = merge({en_r[31:1], 1'b0}, req.wdata, I_PSTRB);

    // The id answered in the setup cycle is the one cleared at the access edge, so the
    // returned value and the cleared bit cannot part even if a new source arrives between.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            claim_id_r <= '0;
        end else if (I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == CIC_CLAIM_ADDR) begin
            claim_id_r <= best_id;
        end
    end

    // Pending bits: hardware sets only; a set in the claim cycle for another source is kept.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            pend_r <= '0;
        end else begin
            for (int i = 1; i <= CIC_NSRC; i++) begin
                if (src_s2_r[i] && !busy_r[i]) begin
                    pend_r[i] <= 1'b1;
                end else if (claim_rd && claim_id_r == CIC_ID_W'(i)) begin
                    pend_r[i] <= 1'b0;
                end
            end
        end
    end

    // Claimed sources stay locked out until their id is written back.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            busy_r <= '0;
        end else begin
            for (int i = 1; i <= CIC_NSRC; i++) begin
                if (claim_rd && claim_id_r == CIC_ID_W'(i)) begin
                    busy_r[i] <= 1'b1;
                end else if (done_wr && done_id == CIC_ID_W'(i)) begin
                    busy_r[i] <= 1'b0;
                end
            end
        end
    end

    // Priority, enable and threshold registers.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            en_r  <= '0;
            thr_r <= CIC_THR_RST;
            for (int i = 1; i <= CIC_NSRC; i++) prio_r[i] <= '0;
        end else if (req.wr) begin
            for (int i = 1; i <= CIC_NSRC; i++) begin
                if (prio_hit(req.addr, i)) prio_r[i] <= req.wdata[CIC_PRIO_W-1:0];
            end
            if (req.addr == CIC_EN_ADDR) begin
                en_r[31:1] <= en_lo_wr[31:1];
            end
            if (req.addr == CIC_EN1_ADDR) begin
                en_r[CIC_NSRC:32] <= req.wdata[CIC_NSRC-32:0];
            end
            if (req.addr == CIC_THR_ADDR) thr_r <= req.wdata[CIC_PRIO_W-1:0];
        end
    end

    // Software interrupt bit.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            swi_r <= 1'b0;
        end else if (req.wr && req.addr == CIC_SWI_ADDR && I_PSTRB[0]) begin
            swi_r <= req.wdata[0];
        end
    end

    // Machine timer: a software write to the count wins over the tick in the same cycle.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            cmp_r <= {CIC_CMP_RST_HI, CIC_CMP_RST_LO};
            cnt_r <= '0;
        end else begin
            if (req.wr && req.addr == CIC_CMPLO_ADDR) begin
                cmp_r[31:0] <= merge(cmp_r[31:0], req.wdata, I_PSTRB);
            end
            if (req.wr && req.addr == CIC_CMPHI_ADDR) begin
                cmp_r[63:32] <= merge(cmp_r[63:32], req.wdata, I_PSTRB);
            end
            if (req.wr && req.addr == CIC_CNTLO_ADDR) begin
                cnt_r[31:0] <= merge(cnt_r[31:0], req.wdata, I_PSTRB);
            end else if (req.wr && req.addr == CIC_CNTHI_ADDR) begin
                cnt_r[63:32] <= merge(cnt_r[63:32], req.wdata, I_PSTRB);
            end else if (tick_s2_r) begin
                cnt_r <= cnt_r + 64'h1;
            end
        end
    end

    // Read mux; the claim read returns the arbiter result of this very cycle.
    always_comb begin
        rdata_nxt = '0;
        hit       = 1'b0;
        for (int i = 1; i <= CIC_NSRC; i++) begin
            if (prio_hit(req.addr, i)) begin
                rdata_nxt = {28'h0, prio_r[i]};
                hit       = 1'b1;
            end
        end
        if (req.addr == CIC_PRIO_BASE) hit = 1'b1;
        case (req.addr)
            CIC_SWI_ADDR:   begin rdata_nxt = {31'h0, swi_r};          hit = 1'b1; end
            CIC_CMPLO_ADDR: begin rdata_nxt = cmp_r[31:0];             hit = 1'b1; end
            CIC_CMPHI_ADDR: begin rdata_nxt = cmp_r[63:32];            hit = 1'b1; end
            CIC_CNTLO_ADDR: begin rdata_nxt = cnt_r[31:0];             hit = 1'b1; end
            CIC_CNTHI_ADDR: begin rdata_nxt = cnt_r[63:32];            hit = 1'b1; end
            CIC_PEND_ADDR:  begin rdata_nxt = {pend_r[31:1], 1'b0};    hit = 1'b1; end
            CIC_PEND1_ADDR: begin rdata_nxt = {19'h0, pend_r[CIC_NSRC:32]}; hit = 1'b1; end
            CIC_EN_ADDR:    begin rdata_nxt = {en_r[31:1], 1'b0};      hit = 1'b1; end
            CIC_EN1_ADDR:   begin rdata_nxt = {19'h0, en_r[CIC_NSRC:32]};   hit = 1'b1; end
            CIC_THR_ADDR:   begin rdata_nxt = {28'h0, thr_r};          hit = 1'b1; end
            CIC_CLAIM_ADDR: begin rdata_nxt = {26'h0, best_id};        hit = 1'b1; end
            default:        begin end
        endcase
    end

    // APB answer registered; PREADY rises in the first access cycle and is dropped after it.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            O_PRDATA  <= '0;
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY  <= I_PSEL & ~I_PENABLE;
            O_PSLVERR <= I_PSEL & ~I_PENABLE & ~hit;
            // Address is already valid in setup, so the read word is taken from the mux then.
            O_PRDATA  <= (I_PSEL & ~I_PENABLE & ~I_PWRITE) ? rdata_nxt : 32'h0;
        end
    end

    // Core-facing lines: locals pass straight through, bypassing the arbiter.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            O_EXT_IRQ   <= 1'b0;
            O_SW_IRQ    <= 1'b0;
            O_TMR_IRQ   <= 1'b0;
            O_LOCAL_IRQ <= '0;
        end else begin
            O_LOCAL_IRQ <= loc_s2_r;
            O_EXT_IRQ   <= (best_id != '0);
            O_SW_IRQ    <= swi_r;
            O_TMR_IRQ   <= (cnt_r >= cmp_r);
        end
    end

    // Highest request under the fixed order; the core still applies its own enables.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            O_IRQ_VEC <= '0;
        end else begin
            O_IRQ_VEC <= '0;
            if      (loc_s2_r[3]) O_IRQ_VEC <= 7'h40;
            else if (loc_s2_r[2]) O_IRQ_VEC <= 7'h20;
            else if (loc_s2_r[1]) O_IRQ_VEC <= 7'h10;
            else if (loc_s2_r[0]) O_IRQ_VEC <= 7'h08;
            else if (best_id != '0) O_IRQ_VEC <= 7'h04;
            else if (swi_r) O_IRQ_VEC <= 7'h02;
            else if (cnt_r >= cmp_r) O_IRQ_VEC <= 7'h01;
        end
    end
endmodule // cic_top
`default_nettype wire

// ---- verification/cic_chk.sv ----
// Purpose: Concurrent checks on the ports of cic_top.
// Assumes: Registered outputs and two sync flops on request inputs.
// Notes:   Latency bounds leave room for one spare register stage (two on the local path), except the software request checks, which are exact.
`timescale 1ns/1ps
`default_nettype none
module cic_chk
    import cic_pkg::*;
(
    input wire logic                  I_CLK,
    input wire logic                  I_RST_B,
    input wire logic                  I_PSEL,
    input wire logic                  I_PENABLE,
    input wire logic                  I_PWRITE,
    input wire logic [31:0]           I_PADDR,
    input wire logic [31:0]           I_PWDATA,
    input wire logic                  O_PREADY,
    input wire logic                  O_PSLVERR,
    input wire logic [CIC_NLOCAL-1:0] I_LOCAL_IRQ,
    input wire logic                  O_EXT_IRQ,
    input wire logic                  O_SW_IRQ,
    input wire logic [CIC_NLOCAL-1:0] O_LOCAL_IRQ,
    input wire logic [6:0]            O_IRQ_VEC
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);
    // A completed write at the edge where it takes effect.
    sequence s_wr(a);
        I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == a;
    endsequence
    a_ready_access: assert property (I_PSEL && !I_PENABLE ##1 I_PENABLE |-> O_PREADY)
        else $error("pready missing in access phase");
    a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
        else $error("pready held past one cycle");
    a_err_ready: assert property (O_PSLVERR |-> O_PREADY && I_PENABLE)
        else $error("pslverr outside a completed access");
    a_swi_set: assert property (s_wr(CIC_SWI_ADDR) ##0 I_PWDATA[0] |-> ##2 O_SW_IRQ)
        else $error("software request not raised");
    a_swi_clr: assert property (s_wr(CIC_SWI_ADDR) ##0 !I_PWDATA[0] |-> ##2 !O_SW_IRQ)
        else $error("software request not cleared");
    a_thr_top: assert property (s_wr(CIC_THR_ADDR) ##0 I_PWDATA[3:0] == 4'hf
        |-> ##3 !O_EXT_IRQ) else $error("external request above top threshold");
    a_local_path: assert property ($stable(I_LOCAL_IRQ) [*5] |-> O_LOCAL_IRQ == I_LOCAL_IRQ)
        else $error("local line not passed through");
    a_vec_onehot: assert property ($onehot0(O_IRQ_VEC))
        else $error("vector names more than one request");
    a_vec_local: assert property (|O_LOCAL_IRQ |-> O_IRQ_VEC[2:0] == 3'h0)
        else $error("lower request beat a local line");
    a_vec_ext: assert property (O_EXT_IRQ && O_LOCAL_IRQ == 4'h0 |-> O_IRQ_VEC == 7'h04)
        else $error("external request not on top");
endmodule // cic_chk
bind cic_top cic_chk u_chk (
    .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .I_LOCAL_IRQ(I_LOCAL_IRQ), .O_EXT_IRQ(O_EXT_IRQ),
    .O_SW_IRQ(O_SW_IRQ), .O_LOCAL_IRQ(O_LOCAL_IRQ), .O_IRQ_VEC(O_IRQ_VEC)
);
`default_nettype wire

// ---- verification/cic_core_model.sv ----
// Purpose: Core-side partner: timer tick source and interrupt acceptance.
// Assumes: Enables mirror the core status and per-type enable bits.
// Notes:   Acceptance is combinational; the core's own latency is ignored.
`timescale 1ns/1ps
`default_nettype none
module cic_core_model
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_tick_on,
    input  wire logic       i_glb_en,
    input  wire logic [6:0] i_type_en,
    input  wire logic [6:0] i_vec,
    output logic            o_tick,
    output logic            o_taken
);
    // Tick every other cycle, so counting is slower than the bus clock.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || !i_tick_on)
            o_tick <= 1'b0;
        else
            o_tick <= !o_tick;
    end
    // A request is taken only with the global and its own type enable.
    assign o_taken = i_glb_en && |(i_vec & i_type_en);
endmodule // cic_core_model
`default_nettype wire

// ---- verification/cic_top_tb.sv ----
// Purpose: Self-checking bench for cic_top over APB.
// Assumes: Zero-wait slave; seed fixed for repeatable stimulus.
// Notes:   Expected claims come from a bench-side arbiter model.
`timescale 1ns/1ps
`default_nettype none
module cic_top_tb
    import cic_pkg::*;
;
    logic i_clk = 1'b0, i_rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic tick_on = 1'b0, glb = 1'b0, err, pready, pslverr, ext, sw, tmr, tick, taken;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd, prdata;
    logic [CIC_NSRC:1] src = '0, en, busy;
    logic [3:0] loc = 4'h0, lcl, thr, prio [1:CIC_NSRC];
    logic [6:0] ten = 7'h00, vec;
    int seed = 90398, n_mismatch = 0, n_compared = 0, k, id;
    always #12.5 i_clk = ~i_clk;
    cic_top dut (.I_CLK(i_clk), .I_RST_B(i_rst_b), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hf),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SRC_IRQ(src),
        .I_LOCAL_IRQ(loc), .I_TIMER_TICK(tick), .O_EXT_IRQ(ext), .O_SW_IRQ(sw),
        .O_TMR_IRQ(tmr), .O_LOCAL_IRQ(lcl), .O_IRQ_VEC(vec));
    cic_core_model core (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_tick_on(tick_on),
        .i_glb_en(glb), .i_type_en(ten), .i_vec(vec), .o_tick(tick), .o_taken(taken));
    task automatic wt(input int c);
        repeat (c) @(posedge i_clk);
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; request held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        @(posedge i_clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        do
            @(posedge i_clk);
        while (pready !== 1'b1 && ++n < 20);
        if (pready !== 1'b1) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Strictly greater wins, so ties keep the lowest identifier.
    function automatic logic [5:0] best_id();
        logic [3:0] bp;
        best_id = 6'h00;
        bp = thr;
        for (int i = 1; i <= CIC_NSRC; i++)
            if (src[i] && en[i] && !busy[i] && prio[i] > bp) begin
                best_id = 6'(i);
                bp = prio[i];
            end
    endfunction
    function automatic logic [6:0] vec_of(input logic [3:0] l);
        vec_of = 7'h00;
        for (int i = 0; i < 4; i++)
            if (l[i]) vec_of = 7'(8 << i);
    endfunction
    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // The whole run needs at most about six hundred cycles.
    initial begin
        wt(20000);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        wt(2);
        i_rst_b <= 1'b1;
        for (k = 0; k < 8; k++) begin
            loc <= (k == 0) ? 4'hf : 4'($random(seed));
            wt(6);
            check("local", 32'(lcl), 32'(loc));
            check("vector", 32'(vec), 32'(vec_of(loc)));
        end
        loc <= 4'h0;
        $display("test locals done");
        apb(1'b1, CIC_SWI_ADDR, 32'h1);
        wt(3);
        check("sw", 32'(sw), 32'h1);
        check("taken off", 32'(taken), 32'h0);
        glb <= 1'b1;
        ten <= 7'h02;
        wt(1);
        check("taken on", 32'(taken), 32'h1);
        apb(1'b1, CIC_SWI_ADDR, 32'h0);
        wt(3);
        check("sw", 32'(sw), 32'h0);
        apb(1'b0, 32'h0c10_0000, 32'h0);
        check("slverr", 32'(err), 32'h1);
        apb(1'b0, CIC_CMPLO_ADDR, 32'h0);
        check("cmp reset", rd, CIC_CMP_RST_LO);
        $display("test software done");
        apb(1'b1, CIC_CMPHI_ADDR, 32'h0);
        apb(1'b1, CIC_CMPLO_ADDR, 32'h14);
        apb(1'b0, CIC_CMPLO_ADDR, 32'h0);
        check("cmp lo", rd, 32'h14);
        tick_on <= 1'b1;
        wt(30);
        check("tmr early", 32'(tmr), 32'h0);
        wt(16);
        check("tmr", 32'(tmr), 32'h1);
        tick_on <= 1'b0;
        apb(1'b0, CIC_CNTLO_ADDR, 32'h0);
        check("count", 32'(rd > 32'h13), 32'h1);
        apb(1'b1, CIC_CNTLO_ADDR, 32'h0);
        wt(3);
        check("tmr cleared", 32'(tmr), 32'h0);
        $display("test timer done");
        for (id = 1; id <= CIC_NSRC; id++) begin
            prio[id] = (id > 31 && id < 35) ? 4'hf : 4'($random(seed));
            apb(1'b1, CIC_PRIO_BASE + 32'(4 * id), 32'(prio[id]));
        end
        en = 44'({$random(seed), $random(seed)}) | 44'h380000000;
        thr = 4'($random(seed)) & 4'h7;
        busy = '0;
        apb(1'b1, CIC_EN_ADDR, {en[31:1], 1'b0});
        apb(1'b1, CIC_EN1_ADDR, {19'h0, en[44:32]});
        apb(1'b1, CIC_THR_ADDR, 32'(thr));
        apb(1'b0, CIC_CLAIM_ADDR, 32'h0);
        check("claim none", rd, 32'h0);
        src <= 44'({$random(seed), $random(seed)}) | 44'h380000000;
        wt(6);
        check("ext", 32'(ext), 32'(best_id() != 6'h00));
        apb(1'b1, CIC_PEND_ADDR, 32'hffff_fffe);
        apb(1'b0, CIC_PEND_ADDR, 32'h0);
        check("pending", rd, {src[31:1], 1'b0});
        apb(1'b1, CIC_THR_ADDR, 32'hf);
        wt(4);
        check("ext top", 32'(ext), 32'h0);
        apb(1'b1, CIC_THR_ADDR, 32'(thr));
        for (k = 0; k < 46; k++) begin
            id = best_id();
            apb(1'b0, CIC_CLAIM_ADDR, 32'h0);
            check("claim", rd, 32'(id));
            if (id == 0) break;
            busy[id] = 1'b1;
            wt(4);
            check("ext busy", 32'(ext), 32'(best_id() != 6'h00));
        end
        apb(1'b1, CIC_CLAIM_ADDR, 32'h20);
        busy[32] = 1'b0;
        wt(6);
        apb(1'b0, CIC_CLAIM_ADDR, 32'h0);
        check("reclaim", rd, 32'h20);
        $display("test external done");
        end_of_test();
    end
endmodule // cic_top_tb
`default_nettype wire
